// ===== ipb_pkg.sv
// Constants, field layout and state types of the interrupt priority bank
package ipb_pkg;

  // Bank geometry
  localparam int IPB_NUM_REGS       = 4;
  localparam int IPB_FIELDS_PER_REG = 4;
  localparam int IPB_NUM_SRC        = IPB_NUM_REGS * IPB_FIELDS_PER_REG;
  localparam int IPB_LVL_W          = 3;
  localparam int IPB_REG_W          = 16;
  localparam int IPB_FIELD_STRIDE   = 4;
  localparam int IPB_ADDR_W         = 12;

  // Register byte offsets on the APB
  localparam logic [IPB_ADDR_W-1:0] IPB_OFS_CAPTURE_CONVERTER_EXTINT = 12'h000;
  localparam logic [IPB_ADDR_W-1:0] IPB_OFS_TIMER_COMPARE_DMA        = 12'h004;
  localparam logic [IPB_ADDR_W-1:0] IPB_OFS_SERIAL_EXTINT_TIMER      = 12'h008;
  localparam logic [IPB_ADDR_W-1:0] IPB_OFS_CAN_AND_SPI              = 12'h00C;

  // Register indices derived from the offsets
  localparam logic [1:0] IPB_IDX_CAPTURE_CONVERTER_EXTINT = 2'h0;
  localparam logic [1:0] IPB_IDX_TIMER_COMPARE_DMA        = 2'h1;
  localparam logic [1:0] IPB_IDX_SERIAL_EXTINT_TIMER      = 2'h2;
  localparam logic [1:0] IPB_IDX_CAN_AND_SPI              = 2'h3;

  // Implemented bits, reset value and the disabled level
  localparam logic [IPB_REG_W-1:0] IPB_REG_MASK     = 16'h7777;
  localparam logic [IPB_REG_W-1:0] IPB_REG_RST      = 16'h4444;
  localparam logic [IPB_LVL_W-1:0] IPB_LVL_DISABLED = 3'h0;

  // Field low-bit positions inside each register
  localparam int IPB_POS_F0 = 0;
  localparam int IPB_POS_F1 = 4;
  localparam int IPB_POS_F2 = 8;
  localparam int IPB_POS_F3 = 12;

  // Whole register bank plus the read data flop
  typedef struct packed {
    logic [IPB_NUM_REGS-1:0][IPB_REG_W-1:0] prio;
    logic [31:0]                            rdata;
  } ipb_state_s;

  // Per-source gate state
  typedef struct packed {
    logic [IPB_LVL_W-1:0] level;
    logic                 req;
  } ipb_gate_s;

endpackage : ipb_pkg

// ===== ipb_src_gate.sv
// Per-source level register and request gate of the priority bank
`timescale 1ns/1ns
module ipb_src_gate
  import ipb_pkg::*;
(
  input  wire logic                          i_clk,
  input  wire logic                          i_rst,
  input  wire logic [ipb_pkg::IPB_LVL_W-1:0] i_level,
  input  wire logic                          i_raw,
  output logic      [ipb_pkg::IPB_LVL_W-1:0] o_level,
  output logic                               o_req
);

  import ipb_pkg::*;

  ipb_gate_s st_r;
  ipb_gate_s st_nxt;

  // Level passes as unsigned value; level zero blocks the request
  always_comb begin
    st_nxt       = st_r;
    st_nxt.level = i_level;
    st_nxt.req   = i_raw && (i_level != IPB_LVL_DISABLED);
  end

  // State register
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_level = st_r.level;
  assign o_req   = st_r.req;

endmodule : ipb_src_gate

// ===== ipb_bank.sv
// APB priority bank for sixteen interrupt sources with request gating
//
// Function
// - Each 3-bit field is an unsigned level, 111 the highest level 7 down to 001 level 1.
// - A field holding 000 disables its source so it never raises a request.
// - Bits 15, 11, 7 and 3 of every register read zero and ignore writes.
// - First register holds capture8 at 14-12, capture7 10-8, converter2 6-4, irq1 2-0.
// - Third register holds serial2 transmit 14-12, receive 10-8, irq2 6-4, timer5 2-0.
`timescale 1ns/1ns
module ipb_bank
  import ipb_pkg::*;
(
  input  wire logic                                       I_SYS_CLK,
  input  wire logic                                       I_SYS_RST,
  input  wire logic                                       I_PSEL,
  input  wire logic                                       I_PENABLE,
  input  wire logic                                       I_PWRITE,
  input  wire logic [ipb_pkg::IPB_ADDR_W-1:0]             I_PADDR,
  input  wire logic [31:0]                                I_PWDATA,
  input  wire logic [3:0]                                 I_PSTRB,
  output logic      [31:0]                                O_PRDATA,
  output logic                                            O_PREADY,
  output logic                                            O_PSLVERR,
  input  wire logic [ipb_pkg::IPB_NUM_SRC-1:0]            I_SRC_RAW,
  output logic      [ipb_pkg::IPB_NUM_SRC-1:0]            O_SRC_REQ,
  output logic      [ipb_pkg::IPB_NUM_SRC*ipb_pkg::IPB_LVL_W-1:0] O_SRC_LEVEL
);

  import ipb_pkg::*;

  ipb_state_s                      st_r;
  ipb_state_s                      st_nxt;
  logic                            addr_ok;
  logic [1:0]                      idx;
  logic                            setup_rd;
  logic                            access;
  logic                            wr_hit;
  logic [IPB_REG_W-1:0]            lane_mask;
  logic [IPB_REG_W-1:0]            wr_val;
  logic [IPB_NUM_SRC*IPB_LVL_W-1:0] levels;
  logic [IPB_NUM_SRC-1:0]          enabled;

  // Named fields of the first and third registers
  logic [IPB_LVL_W-1:0] capture8_priority;
  logic [IPB_LVL_W-1:0] capture7_priority;
  logic [IPB_LVL_W-1:0] converter2_done_priority;
  logic [IPB_LVL_W-1:0] external_irq1_priority;
  logic [IPB_LVL_W-1:0] serial2_transmit_priority;
  logic [IPB_LVL_W-1:0] serial2_receive_priority;
  logic [IPB_LVL_W-1:0] external_irq2_priority;
  logic [IPB_LVL_W-1:0] timer5_priority;

  // Address decode: four aligned words at the bottom of the window
  assign idx      = I_PADDR[3:2];
  assign addr_ok  = (I_PADDR[IPB_ADDR_W-1:4] == '0) && (I_PADDR[1:0] == 2'b00);
  assign setup_rd = I_PSEL && !I_PENABLE && !I_PWRITE;
  assign access   = I_PSEL && I_PENABLE;
  assign wr_hit   = access && I_PWRITE && addr_ok;

  // Byte strobes select the low and high byte of the 16-bit register
  assign lane_mask = {{8{I_PSTRB[1]}}, {8{I_PSTRB[0]}}};

  // Merge of write data into the addressed register, holes forced low
  assign wr_val = ((st_r.prio[idx] & ~lane_mask) |
                   (I_PWDATA[IPB_REG_W-1:0] & lane_mask)) & IPB_REG_MASK;

  // Register bank next state and read data capture in setup phase
  always_comb begin
    st_nxt = st_r;
    if (wr_hit) begin
      st_nxt.prio[idx] = wr_val;
    end
    if (setup_rd) begin
      if (addr_ok) begin
        st_nxt.rdata = {16'h0000, st_r.prio[idx] & IPB_REG_MASK};
      end else begin
        st_nxt.rdata = 32'h0000_0000;
      end
    end
  end

  // State register, every field at level 4 after reset
  always_ff @(posedge I_SYS_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      st_r.prio  <= {IPB_NUM_REGS{IPB_REG_RST}};
      st_r.rdata <= 32'h0000_0000;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Bus answer: no wait states, error on an unmapped word
  assign O_PREADY  = 1'b1;
  assign O_PSLVERR = access && !addr_ok;
  assign O_PRDATA  = st_r.rdata;

  // Field layout of the first register
  assign capture8_priority        = st_r.prio[IPB_IDX_CAPTURE_CONVERTER_EXTINT][IPB_POS_F3 +: IPB_LVL_W];
  assign capture7_priority        = st_r.prio[IPB_IDX_CAPTURE_CONVERTER_EXTINT][IPB_POS_F2 +: IPB_LVL_W];
  assign converter2_done_priority = st_r.prio[IPB_IDX_CAPTURE_CONVERTER_EXTINT][IPB_POS_F1 +: IPB_LVL_W];
  assign external_irq1_priority   = st_r.prio[IPB_IDX_CAPTURE_CONVERTER_EXTINT][IPB_POS_F0 +: IPB_LVL_W];

  // Field layout of the third register
  assign serial2_transmit_priority = st_r.prio[IPB_IDX_SERIAL_EXTINT_TIMER][IPB_POS_F3 +: IPB_LVL_W];
  assign serial2_receive_priority  = st_r.prio[IPB_IDX_SERIAL_EXTINT_TIMER][IPB_POS_F2 +: IPB_LVL_W];
  assign external_irq2_priority    = st_r.prio[IPB_IDX_SERIAL_EXTINT_TIMER][IPB_POS_F1 +: IPB_LVL_W];
  assign timer5_priority           = st_r.prio[IPB_IDX_SERIAL_EXTINT_TIMER][IPB_POS_F0 +: IPB_LVL_W];

  // One gate per source; source n sits in register n/4, field n%4 from bit 0
  for (genvar n = 0; n < IPB_NUM_SRC; n++) begin : g_src
    assign levels[n*IPB_LVL_W +: IPB_LVL_W] =
      st_r.prio[n / IPB_FIELDS_PER_REG][(n % IPB_FIELDS_PER_REG) * IPB_FIELD_STRIDE +: IPB_LVL_W];
    assign enabled[n] = (levels[n*IPB_LVL_W +: IPB_LVL_W] != IPB_LVL_DISABLED);

    ipb_src_gate u_gate (
      .i_clk   (I_SYS_CLK),
      .i_rst   (I_SYS_RST),
      .i_level (levels[n*IPB_LVL_W +: IPB_LVL_W]),
      .i_raw   (I_SRC_RAW[n]),
      .o_level (O_SRC_LEVEL[n*IPB_LVL_W +: IPB_LVL_W]),
      .o_req   (O_SRC_REQ[n])
    );
  end

  // Checks on the bank
  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (I_SYS_RST);

  // Level outputs follow the stored fields unchanged
  level_follow_a: assert property (
    !$past(I_SYS_RST) |-> O_SRC_LEVEL == $past(levels))
    else $error("level output differs from stored field");

  // A request only passes for a source whose field was nonzero
  disabled_src_a: assert property (
    !$past(I_SYS_RST) |-> (O_SRC_REQ & ~$past(enabled)) == '0)
    else $error("request passed for a disabled source");

  // Source 0, when enabled with a raw request, raises its output next cycle
  enabled_src_a: assert property (
    (I_SRC_RAW[0] && enabled[0]) |=> O_SRC_REQ[0])
    else $error("enabled request was dropped");

  // Holes never read back as one
  hole_read_a: assert property (
    (O_PRDATA & 32'hFFFF_8888) == 32'h0000_0000)
    else $error("unimplemented bit read as one");

  // Writing ones into holes leaves them clear
  hole_write_a: assert property (
    wr_hit |=> (st_r.prio[$past(idx)] & ~IPB_REG_MASK) == '0)
    else $error("write reached an unimplemented bit");

  // Capture8 field takes bits 14-12 of a high-byte write to the first register
  capture8_field_a: assert property (
    (wr_hit && I_PSTRB[1] && idx == IPB_IDX_CAPTURE_CONVERTER_EXTINT)
      |=> capture8_priority == $past(I_PWDATA[14:12]))
    else $error("capture8 field not at bits 14-12");

  // Serial transmit field takes bits 14-12 of a high-byte write to the third register
  serial_tx_field_a: assert property (
    (wr_hit && I_PSTRB[1] && idx == IPB_IDX_SERIAL_EXTINT_TIMER)
      |=> serial2_transmit_priority == $past(I_PWDATA[14:12]))
    else $error("serial transmit field not at bits 14-12");

  // Capture7 field takes bits 10-8 of a high-byte write to the first register
  capture7_field_a: assert property (
    (wr_hit && I_PSTRB[1] && idx == IPB_IDX_CAPTURE_CONVERTER_EXTINT)
      |=> capture7_priority == $past(I_PWDATA[10:8]))
    else $error("capture7 field not at bits 10-8");

  // Converter2 field takes bits 6-4 of a low-byte write to the first register
  converter2_field_a: assert property (
    (wr_hit && I_PSTRB[0] && idx == IPB_IDX_CAPTURE_CONVERTER_EXTINT)
      |=> converter2_done_priority == $past(I_PWDATA[6:4]))
    else $error("converter2 field not at bits 6-4");

  // External irq1 field takes bits 2-0 of a low-byte write to the first register
  irq1_field_a: assert property (
    (wr_hit && I_PSTRB[0] && idx == IPB_IDX_CAPTURE_CONVERTER_EXTINT)
      |=> external_irq1_priority == $past(I_PWDATA[2:0]))
    else $error("irq1 field not at bits 2-0");

  // Serial receive field takes bits 10-8 of a high-byte write to the third register
  serial_rx_field_a: assert property (
    (wr_hit && I_PSTRB[1] && idx == IPB_IDX_SERIAL_EXTINT_TIMER)
      |=> serial2_receive_priority == $past(I_PWDATA[10:8]))
    else $error("serial receive field not at bits 10-8");

  // External irq2 field takes bits 6-4 of a low-byte write to the third register
  irq2_field_a: assert property (
    (wr_hit && I_PSTRB[0] && idx == IPB_IDX_SERIAL_EXTINT_TIMER)
      |=> external_irq2_priority == $past(I_PWDATA[6:4]))
    else $error("irq2 field not at bits 6-4");

  // Timer5 field takes bits 2-0 of a low-byte write to the third register
  timer5_field_a: assert property (
    (wr_hit && I_PSTRB[0] && idx == IPB_IDX_SERIAL_EXTINT_TIMER)
      |=> timer5_priority == $past(I_PWDATA[2:0]))
    else $error("timer5 field not at bits 2-0");

  // A low byte whose strobe is low keeps its old bits
  lane_keep_a: assert property (
    (wr_hit && !I_PSTRB[0])
      |=> st_r.prio[$past(idx)][7:0] == $past(st_r.prio[idx][7:0]))
    else $error("write changed a byte whose strobe was low");

  // Every register holds 0x4444 right after reset
  reset_value_a: assert property (
    $past(I_SYS_RST) |-> st_r.prio == {IPB_NUM_REGS{IPB_REG_RST}})
    else $error("register bank not at reset value");

  // Read data in access phase mirrors the register picked in setup
  read_back_a: assert property (
    (setup_rd && addr_ok) |=> O_PRDATA == {16'h0000, $past(st_r.prio[idx])})
    else $error("read data does not match the register");

  // Main scenarios
  cov_write_c:    cover property (wr_hit ##1 setup_rd ##1 access);
  cov_disable_c:  cover property (I_SRC_RAW[4] && !enabled[4]);
  cov_unmapped_c: cover property (O_PSLVERR);
  cov_level7_c:   cover property (serial2_receive_priority == 3'h7 && O_SRC_REQ[10]);
  cov_lane_c:     cover property (wr_hit && I_PSTRB[1:0] == 2'b01);

endmodule : ipb_bank

// ===== ipb_src_model.sv
// Source-side model that presents raw interrupt requests to the bank
`timescale 1ns/1ns
module ipb_src_model (
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic [15:0] i_pattern,
  output logic      [15:0] o_raw
);
  // Requests are levels that follow the bench pattern one edge later
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_raw <= 16'h0000;
    end else begin
      o_raw <= i_pattern;
    end
  end
endmodule : ipb_src_model

// ===== interrupt_priority_bank_5_to_8_bench.sv
// Register and request-gate tests of the interrupt priority bank
`timescale 1ns/1ns
module interrupt_priority_bank_5_to_8_bench;
  import ipb_pkg::*;
  logic                  clk;
  logic                  rst;
  logic                  psel;
  logic                  pen;
  logic                  pwr;
  logic                  pready;
  logic                  pslverr;
  logic                  err;
  logic [IPB_ADDR_W-1:0] paddr;
  logic [31:0]           pwdata;
  logic [3:0]            pstrb;
  logic [31:0]           prdata;
  logic [31:0]           rd;
  logic [15:0]           pat;
  logic [15:0]           raw;
  logic [15:0]           req;
  logic [47:0]           lvl;
  int                    error_cnt = 0;
  int                    n_compared = 0;
  int                    cyc = 0;

  // Device under test and the request sources
  ipb_bank i_ipb_bank (.I_SYS_CLK(clk), .I_SYS_RST(rst), .I_PSEL(psel), .I_PENABLE(pen),
    .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata), .I_PSTRB(pstrb), .O_PRDATA(prdata),
    .O_PREADY(pready), .O_PSLVERR(pslverr), .I_SRC_RAW(raw), .O_SRC_REQ(req),
    .O_SRC_LEVEL(lvl));
  ipb_src_model i_ipb_src_model (.i_clk(clk), .i_rst(rst), .i_pattern(pat), .o_raw(raw));

  // 50 MHz clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic tally_and_finish();
    if (error_cnt == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk(input string what, input logic [47:0] exp, input logic [47:0] got);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // One APB transfer; read data and error taken at the edge where pready is high
  task automatic apb(input logic wr, input logic [IPB_ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb

  // Cut a hang short
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      error_cnt++;
      tally_and_finish();
    end
  end

  // Main sequence
  initial begin
    rst = 1'b1;
    psel = 1'b0;
    pen = 1'b0;
    pwr = 1'b0;
    paddr = '0;
    pwdata = '0;
    pstrb = 4'hF;
    pat = 16'h0000;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    chk("levels after reset", 48'h9249_2492_4924, lvl);
    for (int r = 0; r < 4; r++) begin
      apb(1'b0, 12'(4 * r), 32'h0000_0000);
      chk("reset value", 48'h0000_0000_4444, {16'h0000, rd});
      apb(1'b1, 12'(4 * r), 32'hFFFF_FFFF);
      apb(1'b0, 12'(4 * r), 32'h0000_0000);
      chk("unused bits", 48'h0000_0000_7777, {16'h0000, rd});
    end
    apb(1'b1, IPB_OFS_CAPTURE_CONVERTER_EXTINT, 32'h0000_1357);
    apb(1'b1, IPB_OFS_SERIAL_EXTINT_TIMER, 32'h0000_6420);
    apb(1'b1, IPB_OFS_TIMER_COMPARE_DMA, 32'h0000_0000);
    apb(1'b0, IPB_OFS_CAPTURE_CONVERTER_EXTINT, 32'h0000_0000);
    chk("level readback", 48'h0000_0000_1357, {16'h0000, rd});
    chk("capture levels", {36'h0, 3'd1, 3'd3, 3'd5, 3'd7}, {36'h0, lvl[11:0]});
    chk("serial levels", {36'h0, 3'd6, 3'd4, 3'd2, 3'd0}, {36'h0, lvl[35:24]});
    pat <= 16'hFFFF;
    repeat (3) @(posedge clk);
    chk("gated requests", 48'h0000_0000_FE0F, {32'h0000_0000, req});
    pat <= 16'h0000;
    repeat (3) @(posedge clk);
    chk("requests dropped", 48'h0000_0000_0000, {32'h0000_0000, req});
    // Byte-lane writes into the last register, then a reset in mid-run
    pstrb <= 4'h1;
    apb(1'b1, IPB_OFS_CAN_AND_SPI, 32'h0000_0000);
    pstrb <= 4'h2;
    apb(1'b1, IPB_OFS_CAN_AND_SPI, 32'h0000_3000);
    pstrb <= 4'hF;
    apb(1'b0, IPB_OFS_CAN_AND_SPI, 32'h0000_0000);
    chk("lane writes", 48'h0000_0000_3000, {16'h0000, rd});
    chk("mapped read error", 48'h0000_0000_0000, {47'h0, err});
    chk("can spi levels", {36'h0, 3'd3, 3'd0, 3'd0, 3'd0}, {36'h0, lvl[47:36]});
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    chk("levels after second reset", 48'h9249_2492_4924, lvl);
    apb(1'b0, IPB_OFS_CAN_AND_SPI, 32'h0000_0000);
    chk("second reset value", 48'h0000_0000_4444, {16'h0000, rd});
    apb(1'b0, 12'h010, 32'h0000_0000);
    chk("unmapped error", 48'h0000_0000_0001, {47'h0, err});
    chk("unmapped data", 48'h0000_0000_0000, {16'h0000, rd});
    tally_and_finish();
  end
endmodule : interrupt_priority_bank_5_to_8_bench
